// ### verilog/sgs_pkg.sv
package sgs_pkg;

    localparam int NUM_GAINS = 7;
    localparam int GAIN_W = 16;

    // register byte offsets
    localparam logic [7:0] OFS_SET1_BASE = 8'h00;
    localparam logic [7:0] OFS_SET2_BASE = 8'h20;
    localparam logic [7:0] OFS_CONFIG = 8'h40;
    localparam logic [7:0] OFS_WAIT_UP = 8'h44;
    localparam logic [7:0] OFS_WAIT_DOWN = 8'h48;
    localparam logic [7:0] OFS_RAMP_UP = 8'h4c;
    localparam logic [7:0] OFS_RAMP_DOWN = 8'h50;
    localparam logic [7:0] OFS_STRUCT = 8'h54;
    localparam logic [7:0] OFS_STATUS = 8'h58;
    localparam logic [7:0] OFS_ACTIVE_BASE = 8'h60;

    // gain index within a set
    localparam int IDX_MF_GAIN = 4;
    localparam int IDX_MF_COMP = 5;

    localparam logic [15:0] RST_SPEED_GAIN = 16'h0190;
    localparam logic [15:0] RST_INTEG_TIME = 16'h07d0;
    localparam logic [15:0] RST_POS_GAIN = 16'h0190;
    localparam logic [15:0] RST_TORQ_FILT = 16'h0064;
    localparam logic [15:0] RST_MF_GAIN = 16'h01f4;
    localparam logic [15:0] RST_MF_COMP = 16'h03e8;
    localparam logic [15:0] RST_FRICTION = 16'h0064;
    localparam logic [15:0] RST_TIME = 16'h0000;
    localparam logic [15:0] RST_CONFIG = 16'h0000;

    localparam logic [15:0] MF_GAIN_MIN = 16'h000a;
    localparam logic [15:0] MF_GAIN_MAX = 16'h4e20;

    // config field positions
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_COND_LSB = 4;
    localparam logic [3:0] MODE_MANUAL = 4'h0;
    localparam logic [3:0] MODE_AUTO = 4'h2;

    // one millisecond tick
    localparam int TIME_UNIT_NS = 1000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic position_complete_flag;
        logic near;
        logic ref_filter_busy;
        logic ref_input_on;
        logic pos_ctrl;
        logic cmd_busy;
        logic motor_stopped;
        logic gsel;
    } sgs_status_in_t;

    typedef logic [NUM_GAINS-1:0][GAIN_W-1:0] sgs_gains_t;

endpackage

// ### verilog/sgs_switcher.sv
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// R01: manual mode: command bit 0 selects set 1, bit 1 selects set 2.
// R02: mode digit 2 runs automatic switching, 0 runs manual switching.
// R03: automatic switching only acts under position control.
// R04: condition A true moves set 1 to 2 with wait/ramp time up.
// R05: condition A false moves set 2 to 1 with wait/ramp time down.
// R06: selector 0..3: complete on, complete off, near on, near off.
// R07: selector 4: filter idle and input off; 5: reference input on.
// R08: outside position control, selectors 0,2,4 hold set 1; 1,3,5 set 2.
// R09: after condition change, wait the waiting time before any gain moves.
// R10: gains ramp linearly from old to new over the switching time.
// R11: automatic switching works with both speed loop structures.
// R12: set-2 model-following gain accepts 10..20000, default 500.
// R13: each set holds seven gains; set 2 mirrors set 1.
// R14: model-following gains switch only manually, idle and stopped.
// R15: wait and ramp times are 0..65535 ms, default 0.
// R16: zero ramp time applies the new set in one step after the wait.
module sgs_switcher #(
    parameter int MS_TICKS = sgs_pkg::MS_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire sgs_pkg::sgs_status_in_t STATUS_IN,
    output sgs_pkg::sgs_gains_t GAINS,
    output logic GAIN_SET2_ACTIVE,
    output logic SPEED_STRUCT_IP
);
    import sgs_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RAMP = 3'b100
    } sgs_state_t;

    sgs_status_in_t sync1, sync2;
    sgs_gains_t set1, set2, next_set1, next_set2;
    sgs_gains_t active, next_active, from, next_from;
    logic [15:0] cfg, next_cfg, wait_up, next_wait_up, wait_dn, next_wait_dn;
    logic [15:0] ramp_up, next_ramp_up, ramp_dn, next_ramp_dn;
    logic struct_ip, next_struct_ip;
    logic [31:0] prdata, next_prdata;
    logic pready, next_pready, pslverr, next_pslverr;
    sgs_state_t state, next_state;
    logic target, next_target, sel2, next_sel2;
    logic [15:0] ms_left, next_ms_left, ramp_len, next_ramp_len;
    logic [31:0] tick, next_tick;
    logic cond_a, want2, fixed2, auto_on, wr_now;
    logic [3:0] cond_sel;

    function automatic logic [15:0] lerp(input logic [15:0] a,
        input logic [15:0] b, input logic [15:0] done, input logic [15:0] n);
        logic signed [33:0] diff;
        diff = 34'(signed'({1'b0, b})) - 34'(signed'({1'b0, a}));
        diff = (diff * 34'(signed'({1'b0, done}))) / 34'(signed'({1'b0, n}));
        return 16'(34'(signed'({1'b0, a})) + diff);
    endfunction

    function automatic sgs_gains_t reset_set();
        sgs_gains_t g;
        g[0] = RST_SPEED_GAIN;
        g[1] = RST_INTEG_TIME;
        g[2] = RST_POS_GAIN;
        g[3] = RST_TORQ_FILT;
        g[4] = RST_MF_GAIN;
        g[5] = RST_MF_COMP;
        g[6] = RST_FRICTION;
        return g;
    endfunction

    // pins come from outside the clock domain
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= STATUS_IN;
            sync2 <= sync1;
        end
    end

    // condition A decode
    always_comb
    begin
        cond_sel = cfg[CFG_COND_LSB +: 4];
        unique case (cond_sel)
            4'h0: cond_a = sync2.position_complete_flag; // [R06]
            4'h1: cond_a = !sync2.position_complete_flag; // [R06]
            4'h2: cond_a = sync2.near; // [R06]
            4'h3: cond_a = !sync2.near; // [R06]
            4'h4: cond_a = !sync2.ref_filter_busy // [R07]
                && !sync2.ref_input_on;
            4'h5: cond_a = sync2.ref_input_on; // [R07]
            default: cond_a = 1'b0;
        endcase
        fixed2 = cond_sel[0]; // [R08]
        auto_on = cfg[CFG_MODE_LSB +: 4] == MODE_AUTO; // [R02]
        // structure select does not gate the switcher
        if (auto_on) // [R11]
            want2 = sync2.pos_ctrl ? cond_a : fixed2; // [R03] [R08]
        else
            want2 = sync2.gsel; // [R01]
    end

    // apb slave, one wait state; writes land as the access completes
    always_comb
    begin
        next_set1 = set1;
        next_set2 = set2;
        next_cfg = cfg;
        next_wait_up = wait_up;
        next_wait_dn = wait_dn;
        next_ramp_up = ramp_up;
        next_ramp_dn = ramp_dn;
        next_struct_ip = struct_ip;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        wr_now = PWRITE && pready;
        if (PSEL && PENABLE)
        begin
            next_pready = !pready;
            next_prdata = '0;
            if (PADDR < OFS_SET1_BASE + 8'(NUM_GAINS * 4))
            begin
                next_prdata[15:0] = set1[PADDR[4:2]];
                if (wr_now)
                    next_set1[PADDR[4:2]] = PWDATA[15:0]; // [R13]
            end
            else if (PADDR >= OFS_SET2_BASE
                && PADDR < OFS_SET2_BASE + 8'(NUM_GAINS * 4))
            begin
                next_prdata[15:0] = set2[PADDR[4:2]];
                if (PWRITE)
                begin
                    if (PADDR[4:2] == 3'(IDX_MF_GAIN)
                        && (PWDATA[15:0] < MF_GAIN_MIN
                        || PWDATA[15:0] > MF_GAIN_MAX))
                        next_pslverr = !pready; // [R12]
                    else if (wr_now)
                        next_set2[PADDR[4:2]] = PWDATA[15:0]; // [R12] [R13]
                end
            end
            else if (PADDR >= OFS_ACTIVE_BASE
                && PADDR < OFS_ACTIVE_BASE + 8'(NUM_GAINS * 4))
                next_prdata[15:0] = active[PADDR[4:2]];
            else
            begin
                unique case (PADDR)
                    OFS_CONFIG:
                    begin
                        next_prdata[15:0] = cfg;
                        if (wr_now) next_cfg = PWDATA[15:0];
                    end
                    OFS_WAIT_UP:
                    begin
                        next_prdata[15:0] = wait_up;
                        if (wr_now) next_wait_up = PWDATA[15:0]; // [R15]
                    end
                    OFS_WAIT_DOWN:
                    begin
                        next_prdata[15:0] = wait_dn;
                        if (wr_now) next_wait_dn = PWDATA[15:0]; // [R15]
                    end
                    OFS_RAMP_UP:
                    begin
                        next_prdata[15:0] = ramp_up;
                        if (wr_now) next_ramp_up = PWDATA[15:0]; // [R15]
                    end
                    OFS_RAMP_DOWN:
                    begin
                        next_prdata[15:0] = ramp_dn;
                        if (wr_now) next_ramp_dn = PWDATA[15:0]; // [R15]
                    end
                    OFS_STRUCT:
                    begin
                        next_prdata[0] = struct_ip;
                        if (wr_now) next_struct_ip = PWDATA[0];
                    end
                    OFS_STATUS:
                        next_prdata[3:0] = {state == ST_RAMP,
                            state == ST_WAIT, target, sel2};
                    default:
                        next_pslverr = !pready;
                endcase
            end
        end
    end

    // switching sequencer
    always_comb
    begin
        next_state = state;
        next_target = target;
        next_sel2 = sel2;
        next_ms_left = ms_left;
        next_ramp_len = ramp_len;
        next_tick = tick;
        next_from = from;
        next_active = active;
        next_tick = (tick == 32'(MS_TICKS - 1)) ? '0 : tick + 32'd1;
        if (!auto_on)
        begin
            // manual: immediate step, no ramp
            next_state = ST_IDLE;
            next_target = want2;
            next_sel2 = want2;
        end
        else if (want2 != target)
        begin
            // condition changed: restart timing from current values
            next_target = want2;
            next_state = ST_WAIT; // [R09]
            next_ms_left = want2 ? wait_up : wait_dn; // [R04] [R05]
            next_ramp_len = want2 ? ramp_up : ramp_dn; // [R04] [R05]
            next_tick = '0;
            next_from = active;
        end
        else
        begin
            unique case (state)
                ST_IDLE: ;
                ST_WAIT:
                    if (ms_left == '0)
                    begin
                        next_sel2 = target;
                        next_tick = '0;
                        next_ms_left = ramp_len;
                        next_state = (ramp_len == '0) ? ST_IDLE // [R16]
                            : ST_RAMP; // [R10]
                    end
                    else if (tick == 32'(MS_TICKS - 1))
                        next_ms_left = ms_left - 16'd1; // [R09]
                ST_RAMP:
                    if (ms_left == '0)
                        next_state = ST_IDLE;
                    else if (tick == 32'(MS_TICKS - 1))
                        next_ms_left = ms_left - 16'd1;
            endcase
        end
        // gain output
        for (int i = 0; i < NUM_GAINS; i++)
        begin
            if (i == IDX_MF_GAIN || i == IDX_MF_COMP)
            begin
                // only manual and quiet motor may move these
                if (!auto_on && !sync2.cmd_busy && sync2.motor_stopped)
                    next_active[i] = next_sel2 ? set2[i] : set1[i]; // [R14]
            end
            else if (next_state == ST_RAMP)
                next_active[i] = lerp(from[i],
                    target ? set2[i] : set1[i],
                    ramp_len - next_ms_left, ramp_len); // [R10]
            else if (next_state == ST_IDLE)
                next_active[i] = next_sel2 ? set2[i] : set1[i]; // [R01] [R16]
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            set1 <= reset_set();
            set2 <= reset_set();
            active <= reset_set();
            from <= reset_set();
            cfg <= RST_CONFIG;
            wait_up <= RST_TIME;
            wait_dn <= RST_TIME;
            ramp_up <= RST_TIME;
            ramp_dn <= RST_TIME;
            struct_ip <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            state <= ST_IDLE;
            target <= 1'b0;
            sel2 <= 1'b0;
            ms_left <= '0;
            ramp_len <= '0;
            tick <= '0;
        end
        else
        begin
            set1 <= next_set1;
            set2 <= next_set2;
            active <= next_active;
            from <= next_from;
            cfg <= next_cfg;
            wait_up <= next_wait_up;
            wait_dn <= next_wait_dn;
            ramp_up <= next_ramp_up;
            ramp_dn <= next_ramp_dn;
            struct_ip <= next_struct_ip;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            state <= next_state;
            target <= next_target;
            sel2 <= next_sel2;
            ms_left <= next_ms_left;
            ramp_len <= next_ramp_len;
            tick <= next_tick;
        end
    end

    assign PRDATA = prdata;
    assign PREADY = pready;
    assign PSLVERR = pslverr;
    assign GAINS = active;
    assign GAIN_SET2_ACTIVE = sel2;
    assign SPEED_STRUCT_IP = struct_ip;

    property p_manual_follow;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        !auto_on && $past(!auto_on) |-> sel2 == $past(want2);
    endproperty
    a_manual_follow: assert property (p_manual_follow) // [R01]
        else $error("manual select not followed");

    property p_auto_decode;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        auto_on && !sync2.pos_ctrl |-> want2 == cond_sel[0];
    endproperty
    a_auto_decode: assert property (p_auto_decode) // [R08]
        else $error("fixed set outside position control wrong");

    property p_position_complete_flag_on;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        auto_on && sync2.pos_ctrl && cond_sel == 4'h0 |-> want2 == sync2.position_complete_flag;
    endproperty
    a_position_complete_flag_on: assert property (p_position_complete_flag_on) // [R06]
        else $error("condition a decode wrong");

    property p_wait_hold;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        state == ST_WAIT && ms_left != '0 |=> $stable(sel2);
    endproperty
    a_wait_hold: assert property (p_wait_hold) // [R09]
        else $error("set changed during waiting time");

    property p_wait_load;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        auto_on && want2 && !target |=> state == ST_WAIT
            && ms_left == $past(wait_up) && ramp_len == $past(ramp_up);
    endproperty
    a_wait_load: assert property (p_wait_load) // [R04]
        else $error("up transition timing not loaded");

    property p_wait_load_dn;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        auto_on && !want2 && target |=> state == ST_WAIT
            && ms_left == $past(wait_dn) && ramp_len == $past(ramp_dn);
    endproperty
    a_wait_load_dn: assert property (p_wait_load_dn) // [R05]
        else $error("down transition timing not loaded");

    property p_zero_ramp;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        state == ST_WAIT && ms_left == '0 && ramp_len == '0
            && want2 == target |=> state == ST_IDLE && sel2 == target;
    endproperty
    a_zero_ramp: assert property (p_zero_ramp) // [R16]
        else $error("zero ramp did not step");

    property p_ramp_end;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        state == ST_RAMP && ms_left == '0 && want2 == target
            |=> active[2] == (target ? set2[2] : set1[2]);
    endproperty
    a_ramp_end: assert property (p_ramp_end) // [R10]
        else $error("ramp did not end on new value");

    property p_mf_auto;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        auto_on |=> $stable(active[IDX_MF_GAIN]) || !$past(auto_on);
    endproperty
    a_mf_auto: assert property (p_mf_auto) // [R14]
        else $error("model gain switched automatically");

    c_auto_up: cover property (@(posedge CLK_SYS) state == ST_WAIT
        ##[1:1000] state == ST_RAMP);
    c_zero: cover property (@(posedge CLK_SYS) state == ST_WAIT
        ##1 state == ST_IDLE);
    c_manual: cover property (@(posedge CLK_SYS) !auto_on && $rose(sel2));
endmodule // sgs_switcher

// ### tb/sgs_host_model.sv
`timescale 1ns/1ps
// host side: registers the servo command and status lines once per edge
module sgs_host_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire sgs_pkg::sgs_status_in_t cmd,
    output sgs_pkg::sgs_status_in_t status_in
);
    import sgs_pkg::*;
    sgs_status_in_t next_status;

    always_comb
    begin
        next_status = cmd;
    end

    // registered so every line changes together, never mid-cycle
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            status_in <= '0;
        else
            status_in <= next_status;
    end
endmodule // sgs_host_model

// ### tb/servo_gain_set_switcher_tb.sv
`timescale 1ns/1ps
module servo_gain_set_switcher_tb;
    import sgs_pkg::*;
    logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
    logic set2, struct_ip, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    sgs_status_in_t host_cmd, status_in;
    sgs_gains_t gains;
    logic [15:0] dflt [7];
    int miscompares = 0;
    int tests_run = 0;

    sgs_switcher #(.MS_TICKS(10)) dut (.CLK_SYS(clk_sys), .RESET_N(reset_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .STATUS_IN(status_in), .GAINS(gains),
        .GAIN_SET2_ACTIVE(set2), .SPEED_STRUCT_IP(struct_ip));
    sgs_host_model host (.clk_sys(clk_sys), .reset_n(reset_n),
        .cmd(host_cmd), .status_in(status_in));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            check(32'h0, 32'h1);
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check({31'h0, err}, 32'h0);
    endtask

    task automatic drive(input sgs_status_in_t s);
        @(posedge clk_sys);
        host_cmd <= s;
    endtask

    // bounded wait on the speed gain, which differs per set like the model-following gain
    task automatic wait_gain(input logic [15:0] exp, input int limit);
        int n;
        n = 0;
        while (gains[0] !== exp && n < limit)
        begin
            @(posedge clk_sys);
            n++;
        end
        check({16'h0, gains[0]}, {16'h0, exp});
    endtask

    function automatic sgs_status_in_t cond_in(input int c, input logic a);
        sgs_status_in_t s;
        s = '0;
        s.pos_ctrl = 1'b1;
        s.motor_stopped = 1'b1;
        case (c)
            0: s.position_complete_flag = a;
            1: s.position_complete_flag = !a;
            2: s.near = a;
            3: s.near = !a;
            4: s.ref_filter_busy = !a;
            default: s.ref_input_on = a;
        endcase
        return s;
    endfunction

    task automatic t_reset();
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, OFS_SET1_BASE + 8'(4 * i), 32'h0);
            check(rd, {16'h0, dflt[i]});
            apb(1'b0, OFS_SET2_BASE + 8'(4 * i), 32'h0);
            check(rd, {16'h0, dflt[i]});
            check({16'h0, gains[i]}, {16'h0, dflt[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, OFS_WAIT_UP + 8'(4 * i), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 8'hfc, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset and map done");
    endtask

    task automatic t_mf_range();
        logic [15:0] v [4] = '{16'h0009, 16'h000a, 16'h4e20, 16'h4e21};
        logic e [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, OFS_SET2_BASE + 8'h10, {16'h0, v[i]});
            check({31'h0, err}, {31'h0, e[i]});
        end
        apb(1'b0, OFS_SET2_BASE + 8'h10, 32'h0);
        check(rd, 32'h0000_4e20);
        $display("test model gain range done");
    endtask

    task automatic t_manual();
        sgs_status_in_t s;
        wr_ok(OFS_SET2_BASE, 32'h0000_0300);
        wr_ok(OFS_CONFIG, {28'h0, MODE_MANUAL});
        s = '0;
        s.motor_stopped = 1'b1;
        s.gsel = 1'b1;
        drive(s);
        wait_gain(16'h0300, 20);
        repeat (2) @(posedge clk_sys);
        check({31'h0, set2}, 32'h1);
        check({16'h0, gains[4]}, 32'h0000_4e20);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h0000_0003);
        apb(1'b0, OFS_ACTIVE_BASE, 32'h0);
        check(rd, 32'h0000_0300);
        s.gsel = 1'b0;
        s.cmd_busy = 1'b1;
        drive(s);
        wait_gain(16'h0190, 20);
        check({16'h0, gains[4]}, 32'h0000_4e20);
        s.cmd_busy = 1'b0;
        drive(s);
        repeat (8) @(posedge clk_sys);
        check({16'h0, gains[4]}, {16'h0, RST_MF_GAIN});
        $display("test manual switching done");
    endtask

    task automatic t_hold();
        sgs_status_in_t s;
        for (int c = 0; c < 6; c++)
        begin
            s = cond_in(c, 1'b1);
            s.pos_ctrl = 1'b0;
            drive(s);
            wr_ok(OFS_CONFIG, 32'(c * 16 + 2));
            wait_gain(c % 2 ? 16'h0300 : 16'h0190, 20);
        end
        $display("test fixed set outside position control done");
    endtask

    task automatic t_auto();
        wr_ok(OFS_STRUCT, 32'h1);
        repeat (2) @(posedge clk_sys);
        check({31'h0, struct_ip}, 32'h1);
        for (int c = 0; c < 6; c++)
        begin
            drive(cond_in(c, 1'b0));
            wr_ok(OFS_CONFIG, 32'(c * 16 + 2));
            wait_gain(16'h0190, 40);
            drive(cond_in(c, 1'b1));
            wait_gain(16'h0300, 40);
        end
        $display("test automatic conditions done");
    endtask

    task automatic t_timing();
        logic [15:0] g;
        drive(cond_in(0, 1'b0));
        wr_ok(OFS_CONFIG, 32'h2);
        wait_gain(16'h0190, 40);
        wr_ok(OFS_WAIT_UP, 32'h3);
        wr_ok(OFS_RAMP_DOWN, 32'h4);
        drive(cond_in(0, 1'b1));
        repeat (15) @(posedge clk_sys);
        check({16'h0, gains[0]}, 32'h0000_0190);
        wait_gain(16'h0300, 80);
        drive(cond_in(0, 1'b0));
        repeat (25) @(posedge clk_sys);
        g = gains[0];
        check({31'h0, g > 16'h0190 && g < 16'h0300}, 32'h1);
        wait_gain(16'h0190, 80);
        $display("test wait and ramp timing done");
    endtask

    initial
    begin
        #50000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        dflt = '{RST_SPEED_GAIN, RST_INTEG_TIME, RST_POS_GAIN, RST_TORQ_FILT,
                 RST_MF_GAIN, RST_MF_COMP, RST_FRICTION};
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        host_cmd = '0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_mf_range();
        t_manual();
        t_hold();
        t_auto();
        t_timing();
        wrap_up();
    end
endmodule // servo_gain_set_switcher_tb
